/* File: hw/pbg_defs.vh */
// Constants for the port B general-purpose pin block
// Assumes a 32-bit AXI4-Lite register bus and one core clock
`ifndef PBG_DEFS_VH
`define PBG_DEFS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PBG_IDX_PIN_DATA      4'h1
`define PBG_IDX_PIN_DIRECTION 4'h5
`define PBG_ADDR_PIN_DATA     {`PBG_IDX_PIN_DATA, 2'h0}
`define PBG_ADDR_PIN_DIR      {`PBG_IDX_PIN_DIRECTION, 2'h0}
`define PBG_ADDR_ALT_CTRL     6'h20

// ****************************************
// Field positions and reset values
// ****************************************
`define PBG_DIR_RESET         8'h00
`define PBG_CTL_SER_EN        0
`define PBG_CTL_OSC_OUT       1
`define PBG_CTL_OSC_IN        2
`define PBG_CTL_ADC_EN        3
`define PBG_CTL_ADC_LO        4
`define PBG_CTL_ADC_HI        5
`define PBG_CTL_WIDTH         6
`define PBG_CTL_RESET         6'h00

// ****************************************
// Pin assignment
// ****************************************
`define PBG_PIN_OSC_OUT       7
`define PBG_PIN_OSC_IN        6
`define PBG_PIN_SER_RX        1
`define PBG_PIN_SER_TX        0
`define PBG_ADC_PIN_BASE      2

// ****************************************
// AXI responses
// ****************************************
`define PBG_RESP_OKAY         2'h0
`define PBG_RESP_SLVERR       2'h2

`endif

/* File: hw/pbg_port_b.v */
// Eight-pin general-purpose port with alternate pin functions
// Assumes AXI4-Lite master on the core clock; pins are asynchronous
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pbg_defs.vh"

module pbg_port_b #(
    parameter WIDTH = 8
) (
    input  wire              i_core_clk,
    input  wire              i_srst,
    input  wire [5:0]        i_s_axi_awaddr,
    input  wire              i_s_axi_awvalid,
    output reg               o_s_axi_awready,
    input  wire [31:0]       i_s_axi_wdata,
    input  wire [3:0]        i_s_axi_wstrb,
    input  wire              i_s_axi_wvalid,
    output reg               o_s_axi_wready,
    output reg  [1:0]        o_s_axi_bresp,
    output reg               o_s_axi_bvalid,
    input  wire              i_s_axi_bready,
    input  wire [5:0]        i_s_axi_araddr,
    input  wire              i_s_axi_arvalid,
    output reg               o_s_axi_arready,
    output reg  [31:0]       o_s_axi_rdata,
    output reg  [1:0]        o_s_axi_rresp,
    output reg               o_s_axi_rvalid,
    input  wire              i_s_axi_rready,
    input  wire [WIDTH-1:0]  i_pin,
    output reg  [WIDTH-1:0]  o_pin,
    output reg  [WIDTH-1:0]  o_pin_oe,
    output reg  [WIDTH-1:0]  o_pin_analog,
    input  wire              i_clkgen_osc_out_en,
    input  wire              i_clkgen_osc_in_en,
    input  wire              i_clkgen_osc_out,
    output reg               o_external_clock_in,
    input  wire              i_serial_tx,
    output reg               o_serial_rx,
    output reg  [7:0]        o_ctrl_readback
);

    // ****************************************
    // Storage
    // ****************************************
    reg  [WIDTH-1:0]              pin_latch_bits_q;
    reg  [WIDTH-1:0]              pin_direction_bits_q;
    reg  [`PBG_CTL_WIDTH-1:0]     alt_ctrl_q;
    wire [WIDTH-1:0]              pin_level_q;
    genvar                        g;
    reg  [5:0]                    awaddr_q;
    reg  [7:0]                    wdata_q;
    reg                           wstrb0_q;
    reg                           aw_held_q;
    reg                           w_held_q;

    // ****************************************
    // Alternate function ownership
    // ****************************************
    reg  [WIDTH-1:0]              analog_sel;
    reg  [WIDTH-1:0]              alt_own;
    reg  [WIDTH-1:0]              pin_d;
    reg  [WIDTH-1:0]              oe_d;
    wire [WIDTH-1:0]              read_view;
    wire                          ser_en   = alt_ctrl_q[`PBG_CTL_SER_EN];
    wire                          osc_out  = alt_ctrl_q[`PBG_CTL_OSC_OUT] & i_clkgen_osc_out_en;
    wire                          osc_in   = alt_ctrl_q[`PBG_CTL_OSC_IN] & i_clkgen_osc_in_en;
    wire [1:0]                    adc_chan = alt_ctrl_q[`PBG_CTL_ADC_HI:`PBG_CTL_ADC_LO];

    always @* begin
        analog_sel = {WIDTH{1'b0}};
        if (alt_ctrl_q[`PBG_CTL_ADC_EN]) begin
            analog_sel[`PBG_ADC_PIN_BASE + adc_chan] = 1'b1;
        end
        alt_own = analog_sel;
        alt_own[`PBG_PIN_OSC_OUT] = osc_out | analog_sel[`PBG_PIN_OSC_OUT];
        alt_own[`PBG_PIN_OSC_IN]  = osc_in | analog_sel[`PBG_PIN_OSC_IN];
        alt_own[`PBG_PIN_SER_RX]  = ser_en;
        alt_own[`PBG_PIN_SER_TX]  = ser_en;
        // Ordinary pins: direction gates buffer, latch drives it
        pin_d = pin_latch_bits_q;
        oe_d  = pin_direction_bits_q & ~alt_own;
        pin_d[`PBG_PIN_OSC_OUT] = osc_out ? i_clkgen_osc_out
                                          : pin_latch_bits_q[`PBG_PIN_OSC_OUT];
        oe_d[`PBG_PIN_OSC_OUT]  = oe_d[`PBG_PIN_OSC_OUT] | osc_out;
        pin_d[`PBG_PIN_SER_TX]  = ser_en ? i_serial_tx
                                         : pin_latch_bits_q[`PBG_PIN_SER_TX];
        oe_d[`PBG_PIN_SER_TX]   = oe_d[`PBG_PIN_SER_TX] | ser_en;
        // Analog selection wins over every digital use
        oe_d = oe_d & ~analog_sel;
    end

    // ****************************************
    // Data register read view
    // ****************************************
    // Owned pins still follow direction; software sees latch or level
    // Pin with direction clear shows the filtered level, never the latch
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_read_view
            assign read_view[g] = pin_direction_bits_q[g] ? pin_latch_bits_q[g]
                                                          : pin_level_q[g];
        end
    endgenerate

    // ****************************************
    // Pin sampling and drive
    // ****************************************
    // One sampler per pin; only stage two reads the metastable first stage
    // Level moves once stages two and three agree, so one-edge spikes drop out
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_pin_sync
            reg  stage1_q;
            reg  stage2_q;
            reg  stage3_q;
            reg  level_q;
            always @(posedge i_core_clk) begin
                stage1_q <= i_pin[g];
                stage2_q <= stage1_q;
                stage3_q <= stage2_q;
                if (stage2_q && stage3_q) begin
                    level_q <= 1'b1;
                end else if (!stage2_q && !stage3_q) begin
                    level_q <= 1'b0;
                end
            end
            assign pin_level_q[g] = level_q;
        end
    endgenerate

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_pin               <= {WIDTH{1'b0}};
            o_pin_oe            <= {WIDTH{1'b0}};
            o_pin_analog        <= {WIDTH{1'b0}};
        end else begin
            o_pin               <= pin_d;
            o_pin_oe            <= oe_d;
            o_pin_analog        <= analog_sel;
        end
    end

    // ****************************************
    // Peripheral side inputs
    // ****************************************
    // Released receive line idles high so the serial unit sees no start bit
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_external_clock_in <= 1'b0;
            o_serial_rx         <= 1'b1;
        end else begin
            o_external_clock_in <= osc_in & pin_level_q[`PBG_PIN_OSC_IN];
            o_serial_rx         <= ser_en ? pin_level_q[`PBG_PIN_SER_RX] : 1'b1;
        end
    end

    // ****************************************
    // Control readback
    // ****************************************
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ctrl_readback     <= 8'h00;
        end else begin
            o_ctrl_readback     <= {{(8-`PBG_CTL_WIDTH){1'b0}}, alt_ctrl_q};
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    wire aw_have = aw_held_q | (i_s_axi_awvalid & o_s_axi_awready);
    wire w_have  = w_held_q | (i_s_axi_wvalid & o_s_axi_wready);
    wire [5:0] wa   = aw_held_q ? awaddr_q : i_s_axi_awaddr;
    wire [7:0] wd   = w_held_q ? wdata_q : i_s_axi_wdata[7:0];
    wire       wb0  = w_held_q ? wstrb0_q : i_s_axi_wstrb[0];
    wire       do_w = aw_have & w_have & ~o_s_axi_bvalid;
    wire       latch_store = do_w & wb0 & (wa == `PBG_ADDR_PIN_DATA);

    // Data latches carry no reset so power-up content stays undefined
    always @(posedge i_core_clk) begin
        if (latch_store) begin
            pin_latch_bits_q <= wd[WIDTH-1:0];
        end
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            pin_direction_bits_q <= `PBG_DIR_RESET;
            alt_ctrl_q           <= `PBG_CTL_RESET;
            o_s_axi_bvalid       <= 1'b0;
            o_s_axi_bresp        <= `PBG_RESP_OKAY;
            aw_held_q            <= 1'b0;
            w_held_q             <= 1'b0;
            awaddr_q             <= 6'h00;
            wdata_q              <= 8'h00;
            wstrb0_q             <= 1'b0;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready && !do_w) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready && !do_w) begin
                w_held_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata[7:0];
                wstrb0_q <= i_s_axi_wstrb[0];
            end
            if (do_w) begin
                aw_held_q      <= 1'b0;
                w_held_q       <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= `PBG_RESP_OKAY;
                case (wa)
                    `PBG_ADDR_PIN_DATA: begin
                    end
                    `PBG_ADDR_PIN_DIR: begin
                        if (wb0) begin
                            pin_direction_bits_q <= wd[WIDTH-1:0];
                        end
                    end
                    `PBG_ADDR_ALT_CTRL: begin
                        if (wb0) begin
                            alt_ctrl_q <= wd[`PBG_CTL_WIDTH-1:0];
                        end
                    end
                    default: begin
                        o_s_axi_bresp <= `PBG_RESP_SLVERR;
                    end
                endcase
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Write channel readiness
    // ****************************************
    // Ready only while nothing of that channel is held
    // One-cycle pulses cost a cycle but never accept a second beat early
    wire aw_ready_d = ~aw_have & ~o_s_axi_bvalid & ~do_w & ~o_s_axi_awready;
    wire w_ready_d  = ~w_have & ~o_s_axi_bvalid & ~do_w & ~o_s_axi_wready;

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
        end else begin
            o_s_axi_awready <= aw_ready_d;
            o_s_axi_wready  <= w_ready_d;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h0000_0000;
            o_s_axi_rresp   <= `PBG_RESP_OKAY;
        end else begin
            o_s_axi_arready <= ~o_s_axi_rvalid & ~o_s_axi_arready & i_s_axi_arvalid;
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp  <= `PBG_RESP_OKAY;
                o_s_axi_rdata  <= 32'h0000_0000;
                case (i_s_axi_araddr)
                    `PBG_ADDR_PIN_DATA: begin
                        o_s_axi_rdata[WIDTH-1:0] <= read_view;
                    end
                    `PBG_ADDR_PIN_DIR: begin
                        o_s_axi_rdata[WIDTH-1:0] <= pin_direction_bits_q;
                    end
                    `PBG_ADDR_ALT_CTRL: begin
                        o_s_axi_rdata[`PBG_CTL_WIDTH-1:0] <= alt_ctrl_q;
                    end
                    default: begin
                        o_s_axi_rresp <= `PBG_RESP_SLVERR;
                    end
                endcase
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: test/pbg_port_b_asserts.sv */
// Checker for the port B pin block, bound to its top module
// Assumes one core clock and synchronous active-high reset
`timescale 1ns/100ps
`include "pbg_defs.vh"
module pbg_port_b_asserts (
    input wire       i_core_clk,
    input wire       i_srst,
    input wire [5:0] i_s_axi_araddr,
    input wire       i_s_axi_arvalid,
    input wire       o_s_axi_arready,
    input wire [1:0] o_s_axi_rresp,
    input wire       o_s_axi_rvalid,
    input wire [7:0] o_pin,
    input wire [7:0] o_pin_oe,
    input wire [7:0] o_pin_analog,
    input wire       i_clkgen_osc_out_en,
    input wire       i_clkgen_osc_in_en,
    input wire       i_clkgen_osc_out,
    input wire       o_external_clock_in,
    input wire       i_serial_tx,
    input wire       o_serial_rx,
    input wire [7:0] o_ctrl_readback
);
    // ****************
    // Properties
    // ****************
    // Stable guards allow one cycle of pin register lag
    wire [7:0] ctl = o_ctrl_readback;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    chk_dir_reset: assert property ($fell(i_srst) |-> o_pin_oe == 8'h00)
        else $error("pins drive after reset");
    chk_analog_nodrv: assert property ((o_pin_analog & o_pin_oe) == 8'h00)
        else $error("analog pin driven");
    chk_analog_sel: assert property ($stable(ctl) |->
        o_pin_analog == (ctl[3] ? 8'h04 << ctl[5:4] : 8'h00)) else $error("analog select");
    chk_tx_owned: assert property (ctl[0] && $stable(ctl) && $stable(i_serial_tx)
        |-> o_pin_oe[0] && o_pin[0] == i_serial_tx) else $error("tx pin not serial");
    chk_rx_owned: assert property ($stable(ctl)
        |-> (ctl[0] ? !o_pin_oe[1] : o_serial_rx)) else $error("rx pin ownership");
    chk_osc_out: assert property (ctl[1] && i_clkgen_osc_out_en
        && $stable({ctl, i_clkgen_osc_out_en, i_clkgen_osc_out})
        |-> o_pin_oe[7] && o_pin[7] == i_clkgen_osc_out) else $error("clock out pin");
    chk_osc_in: assert property ($stable({ctl, i_clkgen_osc_in_en}) |->
        (ctl[2] && i_clkgen_osc_in_en ? !o_pin_oe[6] : !o_external_clock_in))
        else $error("clock in pin");
    chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
        |=> o_s_axi_rvalid) else $error("late read answer");
    chk_unmapped_err: assert property (i_s_axi_arvalid && o_s_axi_arready
        && !(i_s_axi_araddr inside {6'h04, 6'h14, 6'h20})
        |=> o_s_axi_rresp == `PBG_RESP_SLVERR) else $error("unmapped read okay");
endmodule
bind pbg_port_b pbg_port_b_asserts u_chk (.*);

/* File: test/pbg_pin_model.sv */
// Board side of the eight port pins
// Assumes board drive changes only after core clock edges
`timescale 1ns/100ps
module pbg_pin_model (
    input  wire       i_core_clk,
    input  wire [7:0] i_out,
    input  wire [7:0] i_oe,
    input  wire [7:0] i_drv,
    input  wire [7:0] i_drv_en,
    output wire [7:0] o_lvl
);
    // Undriven pins flip so a stale level never passes
    reg [7:0] last_q = 8'h00;
    assign o_lvl = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv) | (~i_oe & ~i_drv_en & ~last_q);
    always @(posedge i_core_clk) begin
        last_q <= o_lvl;
    end
endmodule

/* File: test/pbg_port_b_tb_top.sv */
// Self-checking bench for the port B pin block
// Assumes the board model resolves pin levels
`timescale 1ns/100ps
`include "pbg_defs.vh"
module pbg_port_b_tb_top;
    reg         i_core_clk = 0, i_srst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
    reg         i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
    reg         i_clkgen_osc_out_en = 0, i_clkgen_osc_in_en = 0;
    reg         i_clkgen_osc_out = 0, i_serial_tx = 1;
    reg  [5:0]  i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
    reg  [31:0] i_s_axi_wdata = 0, seed;
    reg  [3:0]  i_s_axi_wstrb = 0;
    reg  [7:0]  brd = 0, lat, dir, ctl, eo, ev, ea, lvl;
    wire        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    wire        o_s_axi_rvalid, o_external_clock_in, o_serial_rx;
    wire [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    wire [31:0] o_s_axi_rdata;
    wire [7:0]  i_pin, o_pin, o_pin_oe, o_pin_analog, o_ctrl_readback;
    integer     fail_count = 0, checked = 0, k;
    pbg_port_b dut (.*);
    pbg_pin_model u_brd (.i_core_clk(i_core_clk), .i_out(o_pin), .i_oe(o_pin_oe),
        .i_drv(brd), .i_drv_en(8'hff), .o_lvl(i_pin));
    always #10 i_core_clk = ~i_core_clk;
    // ****************
    // Tasks
    // ****************
    task finish_test;
        begin
            $display("checked %0d fail_count %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task guard(input integer n);
        if (n >= 40) begin
            fail_count = fail_count + 1;
            finish_test;
        end
    endtask
    task wr(input [5:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
        integer n;
        begin
            n = 0;
            @(posedge i_core_clk);
            {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_wstrb} <= {a, 24'h0, d, s};
            {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
            do begin
                @(posedge i_core_clk);
                if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
                if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
                n = n + 1;
            end while (!o_s_axi_bvalid && n < 40);
            i_s_axi_bready <= 1'b0;
            guard(n);
            cmp(o_s_axi_bresp, er);
        end
    endtask
    task rd(input [5:0] a, input [7:0] ed, input [1:0] er, input dc);
        integer n;
        begin
            n = 0;
            @(posedge i_core_clk);
            i_s_axi_araddr <= a;
            {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
            do begin
                @(posedge i_core_clk);
                if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
                n = n + 1;
            end while (!o_s_axi_rvalid && n < 40);
            i_s_axi_rready <= 1'b0;
            guard(n);
            if (dc) cmp(o_s_axi_rdata, {24'h0, ed});
            cmp(o_s_axi_rresp, er);
        end
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        seed = 32'hd3dc;
        repeat (8) @(posedge i_core_clk);
        i_srst <= 1'b0;
        rd(`PBG_ADDR_PIN_DIR, 8'h00, 2'h0, 1);
        cmp(o_pin_oe, 8'h00);
        for (k = 0; k < 24; k = k + 1) begin
            {lat, dir, brd} = {$random(seed), $random(seed)};
            ctl = $random(seed) & 8'h3f;
            {i_serial_tx, i_clkgen_osc_out, i_clkgen_osc_out_en, i_clkgen_osc_in_en} <= $random(seed);
            wr(`PBG_ADDR_PIN_DATA, lat, 4'h1, 2'h0);
            wr(`PBG_ADDR_PIN_DIR, dir, 4'h1, 2'h0);
            wr(`PBG_ADDR_ALT_CTRL, ctl, 4'h1, 2'h0);
            // Input filter needs four edges before reads settle
            repeat (6) @(posedge i_core_clk);
            {eo, ev} = {dir, lat};
            if (ctl[0]) {eo[1:0], ev[0]} = {2'b01, i_serial_tx};
            if (ctl[1] && i_clkgen_osc_out_en) {eo[7], ev[7]} = {1'b1, i_clkgen_osc_out};
            if (ctl[2] && i_clkgen_osc_in_en) eo[6] = 1'b0;
            ea = ctl[3] ? 8'h04 << ctl[5:4] : 8'h00;
            eo = eo & ~ea;
            lvl = (eo & ev) | (~eo & brd);
            cmp(o_pin_oe, eo);
            cmp(o_pin & eo, ev & eo);
            cmp(o_pin_analog, ea);
            cmp(o_ctrl_readback, ctl);
            cmp(o_serial_rx, ctl[0] ? brd[1] : 1'b1);
            cmp(o_external_clock_in, ctl[2] && i_clkgen_osc_in_en && brd[6]);
            rd(`PBG_ADDR_PIN_DATA, (lat & dir) | (lvl & ~dir), 2'h0, 1);
        end
        wr(`PBG_ADDR_PIN_DIR, ~dir, 4'h0, 2'h0);
        rd(`PBG_ADDR_PIN_DIR, dir, 2'h0, 1);
        wr(6'h08, 8'h5a, 4'h1, 2'h2);
        rd(6'h3c, 8'h00, 2'h2, 0);
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        rd(`PBG_ADDR_PIN_DIR, 8'h00, 2'h0, 1);
        wr(`PBG_ADDR_PIN_DIR, 8'hff, 4'h1, 2'h0);
        rd(`PBG_ADDR_PIN_DATA, lat, 2'h0, 1);
        repeat (2) @(posedge i_core_clk);
        cmp(o_pin, lat);
        finish_test;
    end
endmodule
